// ===== hdl/tpio_map.svh
/*
  Register indices, field positions and reset values of the port block.
  Assumes a word-wide bus slave that multiplies each index by four.
*/
`ifndef TPIO_MAP_SVH
`define TPIO_MAP_SVH

`define TPIO_IDX_W          13
`define TPIO_IDX_SER_LATCH  13'h0004
`define TPIO_IDX_MOT_LATCH  13'h0005
`define TPIO_IDX_ANA_LATCH  13'h0006
`define TPIO_IDX_SER_DRAIN  13'h1f84
`define TPIO_IDX_MOT_DRAIN  13'h1f85
`define TPIO_IDX_SER_DIR    13'h1f8a
`define TPIO_IDX_MOT_DIR    13'h1f8b
`define TPIO_IDX_ANA_DIR    13'h1f8c
`define TPIO_IDX_CONV_CTL   13'h1f90

`define TPIO_RMW_ALIAS_BIT  16
`define TPIO_ADS_BIT        5
`define TPIO_CHAN_MSB       3
`define TPIO_CHAN_LSB       0

`define TPIO_PORT_RST       8'h00
`define TPIO_ADS_RST        1'b1
`define TPIO_CHAN_RST       4'h0

`endif

// ===== hdl/tpio_pkg.sv
/*
  Types shared by the port block files.
  Assumes ports of eight pins each.
*/
package tpio_pkg;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } tpio_pad_type;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] drain;
  } tpio_port_cfg_type;

  typedef enum logic [1:0] {
    TPIO_IDLE   = 2'b00,
    TPIO_BUSY   = 2'b01,
    TPIO_NONSEQ = 2'b10,
    TPIO_SEQ    = 2'b11
  } tpio_htrans_type;

endpackage

// ===== hdl/tpio_pin_bank.sv
/*
  Pin drivers and read view of one eight-pin port.
  Assumes the pad ring resolves level from output and enable.
*/
`timescale 1ns/1ps
module tpio_pin_bank
  import tpio_pkg::*;
(
  input  wire tpio_port_cfg_type cfg_i,
  input  wire logic [7:0]        pin_i,
  input  wire logic              rmw_i,
  output tpio_pad_type           pad_o,
  output logic [7:0]             rd_o
);

  // RL3: open drain only pulls low.
  assign pad_o.o  = cfg_i.latch & ~cfg_i.drain;
  // RL21: drive only output bits.
  assign pad_o.oe = cfg_i.dir & (~cfg_i.drain | ~cfg_i.latch);

  // RL5: latch view for drain bits.
  assign rd_o = rmw_i ? ((cfg_i.drain & cfg_i.latch) |
                         (~cfg_i.drain & pin_i))
                      : pin_i;

endmodule

// ===== hdl/tpio_top.sv
/*
  Three eight-pin ports behind an AHB-Lite slave: serial-shared,
  motor and analog-shared. Assumes a single word-wide master and a
  converter that reads the analog enables and channel outputs.
*/
// Register access over AHB-Lite was chosen for this implementation.
// Behaviour
// RL1: Serial port direction per pin, resets to 0 meaning input.
// RL2: Serial port output latch resets to all zeros.
// RL3: Drain select 0 gives tri-state, 1 gives pull-low open drain.
// RL4: Serial port drain select resets to 0.
// RL5: Read-modify-write read returns latch on drain bits, else pins.
// RL6: Software sets timer pin as output for plain timer use.
// RL7: Motor port direction and latch reset to 0.
// RL8: Motor port drain select resets to 0.
// RL9: Software writes 1 to latches of motor circuit output pins.
// RL10: Software disables second emergency stop before general use.
// RL11: Analog port regs reset to 0, disable flag 1, reads low.
// RL12: Analog pin with direction 0 and latch 1 is digital input.
// RL13: Direction 0, latch 0, flag 0 is analog; clearing flag starts.
// RL14: Analog pin with direction 1 drives its latch.
// RL15: Analog port bit with latch 0 reads 0.
// RL16: Converter channel select picks the converted pin.
// RL17: Software clears latches of analog pins, never outputs them.
// RL18: Software avoids output writes on the port during conversion.
// RL19: Software sets bit 7 latch for debug output.
// RL20: Software avoids bit writes while any analog port bit inputs.
// RL21: Latch reaches pins only on output bits; open drain 1 releases.
`timescale 1ns/1ps
`include "tpio_map.svh"
module tpio_top
  import tpio_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic [7:0]  ser_pin_i,
  output logic [7:0]       ser_pin_o,
  output logic [7:0]       ser_pin_oe_o,
  input  wire logic [7:0]  mot_pin_i,
  output logic [7:0]       mot_pin_o,
  output logic [7:0]       mot_pin_oe_o,
  input  wire logic [7:0]  ana_pin_i,
  output logic [7:0]       ana_pin_o,
  output logic [7:0]       ana_pin_oe_o,
  output logic [7:0]       ana_dig_en_o,
  output logic [7:0]       ana_analog_en_o,
  output logic [3:0]       conv_chan_o,
  output logic             conv_start_o
);

  function automatic logic idx_hit(input logic [12:0] a,
                                   input logic [12:0] b);
    return a == b;
  endfunction

  tpio_port_cfg_type ser_cfg;
  tpio_port_cfg_type mot_cfg;
  tpio_port_cfg_type ana_cfg;
  tpio_pad_type      ser_pad;
  tpio_pad_type      mot_pad;
  tpio_pad_type      ana_pad;
  logic [7:0]        ser_rd;
  logic [7:0]        mot_rd;
  logic [7:0]        ana_rd;
  logic              ads;
  logic [3:0]        chan;
  logic              wr_pend;
  logic [12:0]       wr_idx;
  logic [31:0]       rd_mux;

  wire              addr_take = hsel_i & hready_i & htrans_i[1];
  wire              rd_take   = addr_take & ~hwrite_i;
  wire              wr_take   = addr_take & hwrite_i;
  wire [12:0]       a_idx     = haddr_i[14:2];
  wire              rmw_view  = haddr_i[`TPIO_RMW_ALIAS_BIT];
  wire [7:0]        wd        = hwdata_i[7:0];

  wire wr_ser_latch = wr_pend & idx_hit(wr_idx, `TPIO_IDX_SER_LATCH);
  wire wr_ser_dir   = wr_pend & idx_hit(wr_idx, `TPIO_IDX_SER_DIR);
  wire wr_ser_drain = wr_pend & idx_hit(wr_idx, `TPIO_IDX_SER_DRAIN);
  wire wr_mot_latch = wr_pend & idx_hit(wr_idx, `TPIO_IDX_MOT_LATCH);
  wire wr_mot_dir   = wr_pend & idx_hit(wr_idx, `TPIO_IDX_MOT_DIR);
  wire wr_mot_drain = wr_pend & idx_hit(wr_idx, `TPIO_IDX_MOT_DRAIN);
  wire wr_ana_latch = wr_pend & idx_hit(wr_idx, `TPIO_IDX_ANA_LATCH);
  wire wr_ana_dir   = wr_pend & idx_hit(wr_idx, `TPIO_IDX_ANA_DIR);
  wire wr_conv      = wr_pend & idx_hit(wr_idx, `TPIO_IDX_CONV_CTL);

  // The slave never stalls, so every transfer has one data cycle.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= 13'h0000;
    end else if (hready_i) begin
      wr_pend <= wr_take;
      wr_idx  <= a_idx;
    end
  end

  // RL1: serial direction reset and write.
  // RL2: serial latch reset and write.
  // RL4: serial drain select reset.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_cfg <= {`TPIO_PORT_RST, `TPIO_PORT_RST, `TPIO_PORT_RST};
    end else begin
      if (wr_ser_latch) ser_cfg.latch <= wd;
      if (wr_ser_dir)   ser_cfg.dir   <= wd;
      if (wr_ser_drain) ser_cfg.drain <= wd;
    end
  end

  // RL7: motor direction and latch reset.
  // RL8: motor drain select reset.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mot_cfg <= {`TPIO_PORT_RST, `TPIO_PORT_RST, `TPIO_PORT_RST};
    end else begin
      if (wr_mot_latch) mot_cfg.latch <= wd;
      if (wr_mot_dir)   mot_cfg.dir   <= wd;
      if (wr_mot_drain) mot_cfg.drain <= wd;
    end
  end

  // RL11: analog regs clear, disable flag set.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ana_cfg <= {`TPIO_PORT_RST, `TPIO_PORT_RST, `TPIO_PORT_RST};
      ads     <= `TPIO_ADS_RST;
      chan    <= `TPIO_CHAN_RST;
    end else begin
      if (wr_ana_latch) ana_cfg.latch <= wd;
      if (wr_ana_dir)   ana_cfg.dir   <= wd;
      if (wr_conv) begin
        ads  <= hwdata_i[`TPIO_ADS_BIT];
        chan <= hwdata_i[`TPIO_CHAN_MSB:`TPIO_CHAN_LSB];
      end
    end
  end

  // RL13: start pulse on clearing the flag.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= wr_conv & ads & ~hwdata_i[`TPIO_ADS_BIT];
    end
  end

  tpio_pin_bank u_ser (
    .cfg_i (ser_cfg),
    .pin_i (ser_pin_i),
    .rmw_i (rmw_view),
    .pad_o (ser_pad),
    .rd_o  (ser_rd)
  );

  tpio_pin_bank u_mot (
    .cfg_i (mot_cfg),
    .pin_i (mot_pin_i),
    .rmw_i (rmw_view),
    .pad_o (mot_pad),
    .rd_o  (mot_rd)
  );

  // The analog port has no open-drain choice, so its drain is tied off.
  tpio_pin_bank u_ana (
    .cfg_i ({ana_cfg.latch, ana_cfg.dir, `TPIO_PORT_RST}),
    .pin_i (ana_pin_i),
    .rmw_i (rmw_view),
    .pad_o (ana_pad),
    .rd_o  (ana_rd)
  );

  assign ser_pin_o    = ser_pad.o;
  assign ser_pin_oe_o = ser_pad.oe;
  assign mot_pin_o    = mot_pad.o;
  assign mot_pin_oe_o = mot_pad.oe;
  // RL14: output bits drive the latch.
  assign ana_pin_o    = ana_pad.o;
  assign ana_pin_oe_o = ana_pad.oe;

  // RL12: digital input buffer on latch 1.
  assign ana_dig_en_o    = ~ana_cfg.dir & ana_cfg.latch;
  // RL13: analog path on latch 0, flag 0.
  assign ana_analog_en_o = ~ana_cfg.dir & ~ana_cfg.latch & {8{~ads}};
  // RL16: the written channel select goes to the converter.
  assign conv_chan_o     = chan;

  // RL15: latch 0 bits read low.
  wire [7:0] ana_view = ana_rd & ana_cfg.latch;
  wire [7:0] conv_view = {2'b00, ads, 1'b0, chan};

  assign rd_mux =
    idx_hit(a_idx, `TPIO_IDX_SER_LATCH) ? {24'h00_0000, ser_rd}        :
    idx_hit(a_idx, `TPIO_IDX_SER_DIR)   ? {24'h00_0000, ser_cfg.dir}   :
    idx_hit(a_idx, `TPIO_IDX_SER_DRAIN) ? {24'h00_0000, ser_cfg.drain} :
    idx_hit(a_idx, `TPIO_IDX_MOT_LATCH) ? {24'h00_0000, mot_rd}        :
    idx_hit(a_idx, `TPIO_IDX_MOT_DIR)   ? {24'h00_0000, mot_cfg.dir}   :
    idx_hit(a_idx, `TPIO_IDX_MOT_DRAIN) ? {24'h00_0000, mot_cfg.drain} :
    idx_hit(a_idx, `TPIO_IDX_ANA_LATCH) ? {24'h00_0000, ana_view}      :
    idx_hit(a_idx, `TPIO_IDX_ANA_DIR)   ? {24'h00_0000, ana_cfg.dir}   :
    idx_hit(a_idx, `TPIO_IDX_CONV_CTL)  ? {24'h00_0000, conv_view}     :
    32'h0000_0000;

  // Pins are sampled at the address edge; the data phase shows them.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_o <= rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_wr(logic [12:0] idx);
    (wr_take && a_idx == idx && hready_i) ##1 hready_i;
  endsequence

  sequence s_rd(logic [12:0] idx, logic alias_sel);
    rd_take && a_idx == idx && rmw_view == alias_sel;
  endsequence

  chk_ser_dir_write: assert property ( // RL1
    s_wr(`TPIO_IDX_SER_DIR) |=> (ser_cfg.dir == $past(wd)))
    else $error("serial direction write not stored");

  chk_ser_latch_src: assert property ( // RL2
    !$stable(ser_cfg.latch) |->
      $past(wr_pend && wr_idx == `TPIO_IDX_SER_LATCH))
    else $error("serial latch changed without a write");

  chk_od_rmw_read: assert property ( // RL5
    s_rd(`TPIO_IDX_SER_LATCH, 1'b1) |=>
      hrdata_o[7:0] == $past((ser_cfg.drain & ser_cfg.latch) |
                             (~ser_cfg.drain & ser_pin_i)))
    else $error("read-modify-write view wrong");

  chk_plain_read: assert property ( // RL5
    s_rd(`TPIO_IDX_MOT_LATCH, 1'b0) |=>
      hrdata_o[7:0] == $past(mot_pin_i))
    else $error("plain read not pin level");

  chk_od_release: assert property ( // RL3
    ((mot_pad.oe & mot_cfg.drain & mot_cfg.latch) == 8'h00) &&
    ((ser_pad.o & ser_cfg.drain) == 8'h00))
    else $error("open drain drove high");

  chk_ana_zero_read: assert property ( // RL15
    s_rd(`TPIO_IDX_ANA_LATCH, 1'b0) |=>
      (hrdata_o[7:0] & ~$past(ana_cfg.latch)) == 8'h00)
    else $error("analog bit with latch 0 read high");

  chk_ana_modes: assert property ( // RL12
    ((ana_dig_en_o & ana_analog_en_o) == 8'h00) &&
    (ana_pin_oe_o == ana_cfg.dir) &&
    (((ana_pin_o ^ ana_cfg.latch) & ana_cfg.dir) == 8'h00))
    else $error("analog port mode conflict");

  chk_conv_start: assert property ( // RL13
    s_wr(`TPIO_IDX_CONV_CTL) ##1 ($past(ads) && !ads) |->
      conv_start_o ##1 !conv_start_o)
    else $error("conversion start pulse wrong");

  chk_mot_dir_write: assert property ( // RL7
    s_wr(`TPIO_IDX_MOT_DIR) |=> (mot_cfg.dir == $past(wd)))
    else $error("motor direction write not stored");

  chk_mot_latch_src: assert property ( // RL7
    !$stable(mot_cfg.latch) |->
      $past(wr_pend && wr_idx == `TPIO_IDX_MOT_LATCH))
    else $error("motor latch changed without a write");

  chk_oe_dir_only: assert property ( // RL21
    ((ser_pin_oe_o & ~ser_cfg.dir) | (mot_pin_oe_o & ~mot_cfg.dir) |
     (ana_pin_oe_o & ~ana_cfg.dir)) == 8'h00)
    else $error("pin driven while set as input");

  chk_ana_pin_read: assert property ( // RL15
    s_rd(`TPIO_IDX_ANA_LATCH, 1'b0) |=>
      hrdata_o[7:0] == $past(ana_pin_i & ana_cfg.latch))
    else $error("analog port read not pin and latch");

  chk_conv_chan_write: assert property ( // RL16
    s_wr(`TPIO_IDX_CONV_CTL) |=>
      conv_chan_o == $past(hwdata_i[`TPIO_CHAN_MSB:`TPIO_CHAN_LSB]))
    else $error("channel select write not stored");

  chk_start_source: assert property ( // RL13
    conv_start_o |->
      $past(wr_conv && ads && !hwdata_i[`TPIO_ADS_BIT]))
    else $error("conversion start without flag clear");

endmodule

// ===== tb/tpio_board.sv
/*
  Board model for one eight-pin port: the board drives every pin weakly.
  Assumes the port overrides the board wherever its enable is high.
*/
`timescale 1ns/1ps
module tpio_board (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] ext_i,
  output logic [7:0]      level_o
);
  // released pins follow board
  // An open-drain pin left at 1 shows the board's level, not a high drive.
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ===== tb/tb_three_port_io_with_analog_share.sv
/*
  Self-checking bench of the three-port block over AHB-Lite.
  Assumes a slave that never stalls and one board model per port.
*/
`timescale 1ns/1ps
`include "tpio_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_three_port_io_with_analog_share
  import tpio_pkg::*;
;
  logic        ref_clk_i = 0;
  logic        sys_rst_i = 1;
  logic        hwrite    = 0;
  logic [1:0]  htrans    = TPIO_IDLE;
  logic [31:0] haddr     = 0;
  logic [31:0] hwdata    = 0;
  logic [7:0]  ext [3]   = '{8'ha5, 8'h3c, 8'hf0};
  logic [31:0] hrdata;
  logic [7:0]  po [3];
  logic [7:0]  oe [3];
  logic [7:0]  lv [3];
  logic [7:0]  dig_en;
  logic [7:0]  an_en;
  logic [3:0]  chan;
  logic        hready, hresp, start;
  int          failures, total_checks;
  int          seed = 32'h1e5e590e;
  logic [12:0] lat_ix [3] = '{`TPIO_IDX_SER_LATCH, `TPIO_IDX_MOT_LATCH,
                              `TPIO_IDX_ANA_LATCH};
  logic [12:0] dir_ix [3] = '{`TPIO_IDX_SER_DIR, `TPIO_IDX_MOT_DIR,
                              `TPIO_IDX_ANA_DIR};
  logic [12:0] drn_ix [2] = '{`TPIO_IDX_SER_DRAIN, `TPIO_IDX_MOT_DRAIN};

  always #4 ref_clk_i = ~ref_clk_i;

  tpio_top dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .ser_pin_i(lv[0]), .ser_pin_o(po[0]), .ser_pin_oe_o(oe[0]),
    .mot_pin_i(lv[1]), .mot_pin_o(po[1]), .mot_pin_oe_o(oe[1]),
    .ana_pin_i(lv[2]), .ana_pin_o(po[2]), .ana_pin_oe_o(oe[2]),
    .ana_dig_en_o(dig_en), .ana_analog_en_o(an_en), .conv_chan_o(chan),
    .conv_start_o(start));

  for (genvar g = 0; g < 3; g++) begin : brd
    tpio_board brd_u (.pin_o_i(po[g]), .pin_oe_i(oe[g]), .ext_i(ext[g]),
                      .level_o(lv[g]));
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (hready !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
  endtask

  // Whole-word single transfer; alias_b selects the read-modify-write view.
  task automatic xfer(input logic [12:0] idx, input logic wr,
                      input logic alias_b, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk_i);
    htrans <= TPIO_NONSEQ;
    hwrite <= wr;
    haddr  <= {15'h0, alias_b, 1'b0, idx, 2'b00};
    wait_rdy();
    htrans <= TPIO_IDLE;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK({hready, hresp}, 2'b10)
    #1;
  endtask

  task automatic pulses(output int n);
    n = 0;
    repeat (3) begin
      if (start === 1'b1)
        n++;
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic [7:0]  d, l, r, e;
    logic [3:0]  c;
    logic        f;
    int          n;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    #1;
    `CHK(oe[0] | oe[1] | oe[2], 8'h00)
    `CHK(po[0] | po[1], 8'h00)
    `CHK(dig_en | an_en, 8'h00)
    for (int i = 0; i < 3; i++) begin
      xfer(dir_ix[i], 0, 0, 0, rd);
      `CHK(rd, 32'h0000_0000)
      if (i < 2) begin
        xfer(drn_ix[i], 0, 0, 0, rd);
        `CHK(rd, 32'h0000_0000)
        xfer(drn_ix[i], 1, 0, 32'h0000_00ff, rd);
        xfer(lat_ix[i], 0, 1, 0, rd);
        `CHK(rd, 32'h0000_0000)
      end
    end
    xfer(`TPIO_IDX_ANA_LATCH, 0, 0, 0, rd);
    `CHK(rd, 32'h0000_0000)
    xfer(`TPIO_IDX_CONV_CTL, 0, 0, 0, rd);
    `CHK(rd, 32'h0000_0020)
    xfer(13'h0100, 1, 0, 32'h0000_00ff, rd);
    xfer(13'h0100, 0, 0, 0, rd);
    `CHK(rd, 32'h0000_0000)
    xfer(lat_ix[1], 1, 0, 32'h0000_00ff, rd);
    `CHK(oe[1], 8'h00)
    xfer(lat_ix[1], 0, 1, 0, rd);
    `CHK(rd, 32'h0000_00ff)
    xfer(dir_ix[0], 1, 0, 32'h0000_0080, rd);
    `CHK(oe[0], 8'h80)
    for (int k = 0; k < 40; k++) begin
      n = k % 2;
      d = $random(seed);
      l = $random(seed);
      r = $random(seed);
      @(posedge ref_clk_i);
      ext[n] <= $random(seed);
      xfer(dir_ix[n], 1, 0, {24'h0, d}, rd);
      xfer(drn_ix[n], 1, 0, {24'h0, r}, rd);
      xfer(lat_ix[n], 1, 0, {24'h0, l}, rd);
      `CHK(oe[n], d & (~r | ~l))
      `CHK(po[n] & oe[n], l & ~r & d)
      e = (d & (~r | ~l) & l & ~r) | (~(d & (~r | ~l)) & ext[n]);
      xfer(lat_ix[n], 0, 0, 0, rd);
      `CHK(rd, {24'h0, e})
      xfer(lat_ix[n], 0, 1, 0, rd);
      `CHK(rd, {24'h0, (e & ~r) | (l & r)})
    end
    for (int k = 0; k < 24; k++) begin
      d = $random(seed);
      l = $random(seed);
      f = $random(seed);
      c = $random(seed);
      @(posedge ref_clk_i);
      ext[2] <= $random(seed);
      xfer(`TPIO_IDX_CONV_CTL, 1, 0, {26'h0, 1'b1, 1'b0, c}, rd);
      xfer(dir_ix[2], 1, 0, {24'h0, d}, rd);
      xfer(lat_ix[2], 1, 0, {24'h0, l}, rd);
      xfer(`TPIO_IDX_CONV_CTL, 1, 0, {26'h0, f, 1'b0, c}, rd);
      `CHK(start, ~f)
      `CHK(dig_en, ~d & l)
      `CHK(an_en, ~d & ~l & {8{~f}})
      `CHK(oe[2], d)
      `CHK(po[2] & d, l & d)
      `CHK(chan, c)
      e = (d & l) | (~d & ext[2]);
      xfer(lat_ix[2], 0, 0, 0, rd);
      `CHK(rd, {24'h0, e & l})
    end
    xfer(`TPIO_IDX_CONV_CTL, 1, 0, 32'h0000_0020, rd);
    xfer(`TPIO_IDX_CONV_CTL, 1, 0, 32'h0000_0020, rd);
    pulses(n);
    `CHK(n, 0)
    xfer(dir_ix[2], 1, 0, 32'h0000_0080, rd);
    xfer(lat_ix[2], 1, 0, 32'h0000_0080, rd);
    `CHK(po[2] & oe[2], 8'h80)
    xfer(lat_ix[2], 0, 0, 0, rd);
    `CHK(rd, 32'h0000_0080)
    xfer(`TPIO_IDX_CONV_CTL, 1, 0, 32'h0000_0005, rd);
    pulses(n);
    `CHK(n, 1)
    `CHK(chan, 4'h5)
    @(posedge ref_clk_i);
    sys_rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    #1;
    `CHK(oe[0] | oe[1] | oe[2], 8'h00)
    xfer(`TPIO_IDX_CONV_CTL, 0, 0, 0, rd);
    `CHK(rd, 32'h0000_0020)
    give_verdict();
  end
endmodule
